//--- fieldbus_peer_model.sv
// Purpose: stand-in for the fieldbus peers seen by the coupler
// Assumes: one clock; draws come from the bench
// Notes:   a slave-mode coupler is never handed the token
`timescale 1ns/10ps
module fieldbus_peer_model (
  // clock and draw
  input  wire logic       clk_i,
  input  wire logic       step_i,
  input  wire logic [3:0] draw_i,
  // network state
  output logic            master_o,
  output logic            token_o,
  output logic            exch_o,
  output logic            err_o
);
  ////////////////////////////////////////////////////////////
  // new network state on each step
  always @(posedge clk_i) begin
    if (step_i) begin
      master_o <= draw_i[0];
      token_o  <= draw_i[0] & draw_i[1]; // token only circulates among masters
      exch_o   <= draw_i[2];
      err_o    <= draw_i[3];
    end
  end
endmodule : fieldbus_peer_model

//--- led_status.sv
// Purpose: drives four status indicators of a fieldbus coupler
// Assumes: Avalon-MM slave, synchronous active-high reset
// Notes:   status inputs come from firmware via the control register
//
// What this block does
// RL1: passed self-test lights readiness steadily
// RL2: failed self-test flashes readiness, halts init
// RL3: loader cyclic, system error irregular, defect off
// RL4: communication indicator off until configured
// RL5: parameter or configuration error flashes irregularly
// RL6: ready cyclic, communication active steady on
// RL7: error indicator follows fieldbus error
// RL8: slave mode: exchange lit during data exchange
// RL9: master mode: exchange lit holding token
// RL10: indicators may blink briefly while reconfiguring
// RL11: cyclic even toggle, irregular distinct pattern
`timescale 1ns/10ps
`include "led_status_params.svh"

module led_status
  import led_status_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_SYS_I,
  input  wire logic        SYS_RST_I,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // indicators
  output logic             LED_READY_O,
  output logic             LED_COMM_O,
  output logic             LED_EXCH_O,
  output logic             LED_ERROR_O,
  // interrupt
  output logic             IRQ_O
);
  import led_status_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave
  // every access gets exactly one wait cycle; the answer is registered so
  // waitrequest and readdata both leave flip-flops, traded for latency
  logic [`CTRL_W-1:0] ctrl_ff;      // firmware status bits
  logic [`IRQ_W-1:0]  irq_stat_ff;  // sticky events
  logic [`IRQ_W-1:0]  irq_mask_ff;  // event enables
  logic               ack_ff;       // one-cycle answer phase
  logic               init_halt_ff; // init stopped after failed test
  logic [`IRQ_W-1:0]  evt;          // event pulses this cycle
  logic               req;
  logic               wr_take;

  assign req     = AVS_READ_I | AVS_WRITE_I;
  // each access waits exactly one cycle, taken when waitrequest drops
  assign wr_take = AVS_WRITE_I & ack_ff;

  // answer phase toggles so every request sees one wait cycle
  // waitrequest is always the inverse of ack_ff, so no answer can stretch
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  // waitrequest high unless answering
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      AVS_WAITREQUEST_O <= ~(req & ~ack_ff);
    end
  end

  // control register write; a halted init still takes writes, but the
  // decision logic keeps communication dark and readiness flashing, unless the defect bit turns readiness off
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      ctrl_ff <= '0;
    end else if (wr_take && AVS_ADDRESS_I == `REG_CTRL) begin
      ctrl_ff <= AVS_WRITEDATA_I[`CTRL_W-1:0];
    end
  end

  // mask register write
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      irq_mask_ff <= '0;
    end else if (wr_take && AVS_ADDRESS_I == `REG_IRQ_MASK) begin
      irq_mask_ff <= AVS_WRITEDATA_I[`IRQ_W-1:0];
    end
  end

  // read mux, registered at the answer cycle
  // a write also loads readdata; harmless, it only matters on a read
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      AVS_READDATA_O <= 32'h0;
    end else if (req & ~ack_ff) begin
      unique case (AVS_ADDRESS_I)
        `REG_CTRL:     AVS_READDATA_O <= {{(32-`CTRL_W){1'b0}}, ctrl_ff};
        `REG_STAT:     AVS_READDATA_O <= {27'h0, init_halt_ff, LED_READY_O,
                                          LED_COMM_O, LED_EXCH_O, LED_ERROR_O};
        `REG_IRQ_STAT: AVS_READDATA_O <= {{(32-`IRQ_W){1'b0}}, irq_stat_ff};
        `REG_IRQ_MASK: AVS_READDATA_O <= {{(32-`IRQ_W){1'b0}}, irq_mask_ff};
        // unmapped reads answer zero
        default:       AVS_READDATA_O <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts
  // events are rising edges of status levels; history resets to the idle
  // level so no false event follows reset
  logic bus_err_d_ff;  // edge detect history
  logic fail_d_ff;
  logic cfg_err_d_ff;
  logic test_fail;
  logic cfg_err;

  assign test_fail = ctrl_ff[`CTRL_TEST_DONE] & ~ctrl_ff[`CTRL_TEST_PASS];
  assign cfg_err   = ctrl_ff[`CTRL_PRM_ERR];

  // history of the event levels
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      bus_err_d_ff <= 1'b0;
      fail_d_ff    <= 1'b0;
      cfg_err_d_ff <= 1'b0;
    end else begin
      bus_err_d_ff <= ctrl_ff[`CTRL_BUS_ERR];
      fail_d_ff    <= test_fail;
      cfg_err_d_ff <= cfg_err;
    end
  end

  // one-cycle pulses into the sticky register
  assign evt[`IRQ_BUS_ERR]   = ctrl_ff[`CTRL_BUS_ERR] & ~bus_err_d_ff;
  assign evt[`IRQ_TEST_FAIL] = test_fail & ~fail_d_ff;
  assign evt[`IRQ_CFG_ERR]   = cfg_err & ~cfg_err_d_ff;

  // sticky status, write one clears; a new event beats the clear
  // clearing and setting in one cycle keeps the bit, so no event is lost
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      irq_stat_ff <= '0;
    end else if (wr_take && AVS_ADDRESS_I == `REG_IRQ_STAT) begin
      irq_stat_ff <= (irq_stat_ff & ~AVS_WRITEDATA_I[`IRQ_W-1:0]) | evt;
    end else begin
      irq_stat_ff <= irq_stat_ff | evt;
    end
  end

  // level interrupt from unmasked status
  // one cycle behind the status bits, since the output is a flip-flop
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flash pattern generators
  // both generators free-run from reset so readiness and communication flash in step;
  // the periods run to tens of millions of cycles, too long for short runs
  logic [24:0] cyc_cnt_ff;  // cyclic half-period counter
  logic        cyc_ff;      // cyclic waveform
  logic [25:0] irr_cnt_ff;  // irregular phase counter
  logic [1:0]  irr_ph_ff;   // irregular phase index
  logic        irr_ff;      // irregular waveform
  logic [25:0] irr_len;

  // RL11: even toggle
  // the wrap value is the half period, so on and off times match
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      cyc_cnt_ff <= 25'h0;
      cyc_ff     <= 1'b0;
    end else if (cyc_cnt_ff == 25'(`CYC_HALF_CYCLES - 1)) begin
      cyc_cnt_ff <= 25'h0;
      cyc_ff     <= ~cyc_ff;
    end else begin
      cyc_cnt_ff <= cyc_cnt_ff + 25'h1;
    end
  end

  // phases: short on, short off, short on, long off
  // phase 3 is the long one, which breaks the rhythm of the cyclic flash
  always_comb begin
    irr_len = (irr_ph_ff == 2'h3) ? 26'(`IRR_LONG_CYCLES) : 26'(`IRR_SHORT_CYCLES);
  end

  // RL11: irregular pattern
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      irr_cnt_ff <= 26'h0;
      irr_ph_ff  <= 2'h0;
      irr_ff     <= 1'b1;
    end else if (irr_cnt_ff == irr_len - 26'h1) begin
      irr_cnt_ff <= 26'h0;
      irr_ph_ff  <= irr_ph_ff + 2'h1;
      irr_ff     <= irr_ph_ff[0];
    end else begin
      irr_cnt_ff <= irr_cnt_ff + 26'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicator decisions
  // modes are chosen combinationally and applied in one registered stage
  ind_mode_t ready_mode;
  ind_mode_t comm_mode;

  // RL2: latch halt on failed test
  // the latch only drops at reset: a failed test must not be retried
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      init_halt_ff <= 1'b0;
    end else if (test_fail) begin
      init_halt_ff <= 1'b1;
    end
  end

  // readiness mode, defect has highest priority
  // a defect wins, since a dead unit must never look alive
  always_comb begin
    ready_mode = IND_OFF;
    // RL3: defect dark
    if (ctrl_ff[`CTRL_HW_DEFECT]) begin
      ready_mode = IND_OFF;
    // RL2: failed test flashes
    end else if (init_halt_ff) begin
      ready_mode = IND_CYCLIC;
    // RL3: error irregular
    end else if (ctrl_ff[`CTRL_SYS_ERR]) begin
      ready_mode = IND_IRREGULAR;
    // RL3: loader cyclic
    end else if (ctrl_ff[`CTRL_LOADER]) begin
      ready_mode = IND_CYCLIC;
    // RL1: passed test on
    end else if (ctrl_ff[`CTRL_TEST_DONE] && ctrl_ff[`CTRL_TEST_PASS]) begin
      ready_mode = IND_ON;
    end
  end

  // communication mode; halted init keeps it dark
  // a parameter error outranks the configured state
  always_comb begin
    comm_mode = IND_OFF;
    // RL4: dark until configured
    if (init_halt_ff || !ctrl_ff[`CTRL_TEST_PASS]) begin
      comm_mode = IND_OFF;
    // RL5: config error irregular
    end else if (cfg_err) begin
      comm_mode = IND_IRREGULAR;
    end else if (ctrl_ff[`CTRL_CFG_VALID]) begin
      // RL6: steady or cyclic
      comm_mode = ctrl_ff[`CTRL_COMM_ACT] ? IND_ON : IND_CYCLIC;
    end
  end

  // pick the waveform for a mode; all four modes are listed, no default
  function automatic logic drive(input ind_mode_t m, input logic c, input logic r);
    unique case (m)
      IND_OFF:       drive = 1'b0;
      IND_ON:        drive = 1'b1;
      IND_CYCLIC:    drive = c;
      IND_IRREGULAR: drive = r;
    endcase
  endfunction : drive

  // RL10: registered outputs settle one cycle after a change, readiness two after a failed test
  // a reconfiguration shows at most one cycle of the old mode
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      LED_READY_O <= 1'b0;
      LED_COMM_O  <= 1'b0;
    end else begin
      LED_READY_O <= drive(ready_mode, cyc_ff, irr_ff);
      LED_COMM_O  <= drive(comm_mode, cyc_ff, irr_ff);
    end
  end

  // exchange and error indicators
  // master and slave meanings share one output, chosen by the mode bit
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      LED_EXCH_O  <= 1'b0;
      LED_ERROR_O <= 1'b0;
    end else begin
      // RL9: master token; RL8: slave exchange
      LED_EXCH_O  <= ctrl_ff[`CTRL_MASTER] ? ctrl_ff[`CTRL_TOKEN] : ctrl_ff[`CTRL_EXCH];
      // RL7: follows bus error
      LED_ERROR_O <= ctrl_ff[`CTRL_BUS_ERR];
    end
  end

endmodule : led_status

//--- led_status_params.svh
// Purpose: constants for the coupler status indicator block
// Assumes: 125 MHz system clock (8 ns period)
// Notes:   times in ms, cycle counts derived from the clock rate
`ifndef LED_STATUS_PARAMS_SVH
`define LED_STATUS_PARAMS_SVH

`define CLK_PERIOD_NS      8
// cyclic flash half period
`define CYC_HALF_MS        250
`define CYC_HALF_CYCLES    ((`CYC_HALF_MS * 1000000) / `CLK_PERIOD_NS)
// irregular flash: short and long phases
`define IRR_SHORT_MS       100
`define IRR_SHORT_CYCLES   ((`IRR_SHORT_MS * 1000000) / `CLK_PERIOD_NS)
`define IRR_LONG_MS        400
`define IRR_LONG_CYCLES    ((`IRR_LONG_MS * 1000000) / `CLK_PERIOD_NS)
// bus register offsets (byte addresses)
`define REG_CTRL           4'h0
`define REG_STAT           4'h4
`define REG_IRQ_STAT       4'h8
`define REG_IRQ_MASK       4'hc
// control bits
`define CTRL_TEST_DONE     0
`define CTRL_TEST_PASS     1
`define CTRL_LOADER        2
`define CTRL_SYS_ERR       3
`define CTRL_HW_DEFECT     4
`define CTRL_CFG_VALID     5
`define CTRL_PRM_ERR       6
`define CTRL_MASTER        7
`define CTRL_COMM_ACT      8
`define CTRL_EXCH          9
`define CTRL_TOKEN         10
`define CTRL_BUS_ERR       11
`define CTRL_W             12
// interrupt events
`define IRQ_BUS_ERR        0
`define IRQ_TEST_FAIL      1
`define IRQ_CFG_ERR        2
`define IRQ_W              3

`endif

//--- led_status_pkg.sv
// Purpose: types for the coupler status indicator block
// Assumes: nothing
// Notes:   indicator modes shared by the readiness and communication outputs
package led_status_pkg;
  typedef enum logic [1:0] {
    IND_OFF,
    IND_ON,
    IND_CYCLIC,
    IND_IRREGULAR
  } ind_mode_t;
endpackage : led_status_pkg

//--- led_status_sva.sv
// Purpose: port checks for the status indicator block
// Assumes: indicators settle within 3 cycles of a control write
// Notes:   flash phases are too long to observe, steady states only
`timescale 1ns/10ps
module led_status_sva (
  // clock and reset
  input wire logic        CLK_SYS_I,
  input wire logic        SYS_RST_I,
  // bus
  input wire logic [3:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  // indicators and interrupt
  input wire logic        LED_READY_O,
  input wire logic        LED_COMM_O,
  input wire logic        LED_EXCH_O,
  input wire logic        LED_ERROR_O,
  input wire logic        IRQ_O
);
  logic        wacc;    // accepted control write
  logic [31:0] ctrl_ff; // shadow of the control word
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);
  assign wacc = AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 4'h0;
  // shadow kept so checks need no design internals
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) ctrl_ff <= 32'h0;
    else if (wacc) ctrl_ff <= AVS_WRITEDATA_I;
  end
  // no newer write for 3 cycles, so indicators are steady
  sequence settled;
    wacc ##1 !wacc [*3];
  endsequence
  a_wait_answer: assert property ((AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O
    |=> !AVS_WAITREQUEST_O) else $error("bus request unanswered");
  a_wait_pulse: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low too long");
  a_unmapped_zero: assert property (AVS_READ_I && !AVS_WAITREQUEST_O
    && AVS_ADDRESS_I[1:0] != 2'b00 |-> AVS_READDATA_O == 32'h0) else $error("unmapped read");
  a_err_follow: assert property (settled |-> LED_ERROR_O == ctrl_ff[11])
    else $error("error indicator wrong");
  a_exch_mode: assert property (settled ##0 ctrl_ff[1] |->
    LED_EXCH_O == (ctrl_ff[7] ? ctrl_ff[10] : ctrl_ff[9])) else $error("exchange wrong");
  a_ready_on: assert property (settled ##0 ctrl_ff[4:0] == 5'h03 |-> LED_READY_O)
    else $error("ready not lit");
  a_ready_dead: assert property (settled ##0 ctrl_ff[4] |-> !LED_READY_O)
    else $error("ready lit on defect");
  a_comm_idle: assert property (settled ##0 !ctrl_ff[1] |-> !LED_COMM_O)
    else $error("comm lit before setup");
  a_comm_run: assert property (settled ##0 ctrl_ff[8] && ctrl_ff[6:5] == 2'h1
    && ctrl_ff[1:0] == 2'h3 |-> LED_COMM_O) else $error("comm not steady");
  a_irq_masked: assert property (AVS_WRITE_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 4'hc
    && AVS_WRITEDATA_I[2:0] == 3'h0 |=> ##2 !IRQ_O) else $error("masked irq high");
endmodule : led_status_sva
bind led_status led_status_sva led_status_sva_inst (.CLK_SYS_I(CLK_SYS_I),
  .SYS_RST_I(SYS_RST_I), .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .LED_READY_O(LED_READY_O), .LED_COMM_O(LED_COMM_O), .LED_EXCH_O(LED_EXCH_O),
  .LED_ERROR_O(LED_ERROR_O), .IRQ_O(IRQ_O));

//--- led_status_tb.sv
// Purpose: self-checking bench for the status indicator block
// Assumes: reads carry mask and expected word in a queue
// Notes:   flashing levels are masked out of status reads
`timescale 1ns/10ps
module led_status_tb;
  logic        clk, rst, rd, wr, step, wreq, irq, m, t, x, e;
  logic        lr, lc, lx, le; // indicator pins
  logic [3:0]  adr, draw;
  logic [31:0] wd, rdata;
  logic [63:0] q[$]; // mask and expected word per read
  int          fails, checks;
  led_status led_status_inst (.CLK_SYS_I(clk), .SYS_RST_I(rst), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wreq), .LED_READY_O(lr), .LED_COMM_O(lc), .LED_EXCH_O(lx),
    .LED_ERROR_O(le), .IRQ_O(irq));
  fieldbus_peer_model fieldbus_peer_model_inst (.clk_i(clk), .step_i(step),
    .draw_i(draw), .master_o(m), .token_o(t), .exch_o(x), .err_o(e));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // one bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, mk);
    if (!w) q.push_back({mk, d});
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    rd <= 0;
    wr <= 0;
  endtask : bus
  // write control, read it back, let it settle, read status
  task automatic ctl(input logic [31:0] cv, input logic [4:0] ex, mk);
    bus(1, 4'h0, cv, 0);
    bus(0, 4'h0, cv, 32'hfff);
    repeat (4) @(posedge clk);
    bus(0, 4'h4, {27'h0, ex}, {27'h0, mk});
    chk({28'h0, lr, lc, lx, le} & {28'h0, mk[3:0]}, {28'h0, ex[3:0] & mk[3:0]});
  endtask : ctl
  // oldest note against each read answer
  always @(posedge clk) begin
    if (rd === 1'b1 && wreq === 1'b0 && q.size() > 0) begin
      chk(rdata & q[0][63:32], q[0][31:0] & q[0][63:32]);
      void'(q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    close_out();
  end
  initial begin
    rst = 1;
    {rd, wr, step, adr, draw, wd} = '0;
    void'($urandom(2));
    repeat (10) @(posedge clk);
    rst <= 0;
    bus(0, 4'h4, 32'h0, 32'h1f);
    bus(1, 4'h2, 32'hfff, 0);
    bus(0, 4'h2, 32'h0, 32'hffffffff);
    bus(0, 4'h0, 32'h0, 32'hfff);
    ctl(32'h120, 5'h00, 5'h1f);
    ctl(32'h123, 5'h0c, 5'h1f);
    ctl(32'h003, 5'h08, 5'h1f);
    ctl(32'h023, 5'h08, 5'h1b);
    ctl(32'h127, 5'h04, 5'h17);
    ctl(32'h12b, 5'h04, 5'h17);
    ctl(32'h133, 5'h04, 5'h1f);
    ctl(32'h163, 5'h08, 5'h1b);
    bus(0, 4'h8, 32'h4, 32'h7);
    repeat (8) begin
      draw <= 4'($urandom);
      step <= 1;
      @(posedge clk);
      step <= 0;
      @(posedge clk);
      ctl({20'h0, e, t, x, 1'b1, m, 7'h23}, {3'b011, m ? t : x, e}, 5'h1f);
    end
    bus(1, 4'hc, 32'h7, 0);
    bus(1, 4'h8, 32'h7, 0);
    ctl(32'h123, 5'h0c, 5'h1f);
    ctl(32'h923, 5'h0d, 5'h1f);
    bus(0, 4'h8, 32'h1, 32'h7);
    chk({31'h0, irq}, 32'h1);
    bus(1, 4'hc, 32'h0, 0);
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    bus(0, 4'hc, 32'h0, 32'h7);
    bus(1, 4'h8, 32'h1, 0);
    bus(1, 4'hc, 32'h7, 0);
    repeat (4) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    ctl(32'h001, 5'h10, 5'h17);
    bus(0, 4'h8, 32'h2, 32'h7);
    chk({31'h0, irq}, 32'h1);
    close_out();
  end
endmodule : led_status_tb
